// File: hw/vsw_pkg.sv
// What this block does
// [R1] output one's source select lives in bits 2:0 of the register at address zero.
// [R2] output two's source select lives in bits 6:4 of that same register.
// [R3] after reset output one's select is zero, so video output one is grounded.
// [R4] after reset output two's select is zero, so video output two is grounded.
// [R5] while the power-down pin is low every register returns to its default.
// [R6] the host writes zeros into the fixed bits 7 and 3.
// [R7] the host writes only address zero and never the reserved address one.
// [R8] select value zero grounds the output, values one to seven route inputs one to seven.
// [R9] a strap picks the 3-wire port when low and the two-wire port when high.
// [R10] a 3-wire frame is chip address, write bit, 5-bit address, 8 data bits, latched on edge 16.
// [R11] in a multi-byte two-wire write the address advances after each data byte.
// [R12] fixed bits 7 and 3 and the whole reserved register read as zero.
package vsw_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_INPUT_ROUTE = 5'h00;
  localparam logic [4:0] ADDR_RESERVED = 5'h01;
  localparam logic [7:0] RST_INPUT_ROUTE = 8'h00;
  localparam int SEL1_LSB = 0;
  localparam int SEL2_LSB = 4;
  localparam logic [7:0] ROUTE_RD_MASK = 8'h77;
  // ---------------------------------------------------------------
  // serial framing
  // ---------------------------------------------------------------
  localparam int TW_FRAME_BITS = 16;
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h04;
endpackage

// File: hw/vsw_ctrl.sv
`timescale 1ns/10ps
module vsw_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // pins
  input wire logic power_down_n_pin_i,
  input wire logic i2c_mode_strap_i,
  input wire logic chip_addr_bit_high_i,
  input wire logic chip_addr_bit_low_i,
  // 3-wire port
  input wire logic serial_select_n_i,
  input wire logic serial_clock_in_i,
  input wire logic serial_data_in_i,
  // two-wire port, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // outputs: source index 0 means grounded
  output logic [2:0] output1_source_select_o,
  output logic [2:0] output2_source_select_o,
  output logic [6:0] video_output_one_route_o,
  output logic [6:0] video_output_two_route_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;
  logic pd_n;
  logic strap;
  logic cs_n;
  logic scl;
  logic sda;
  logic sclk_rise;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  // stage one feeds stage two only; edges use stages two and three
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg <= 8'hff;
      s2_reg <= 8'hff;
      s3_reg <= 8'hff;
    end else begin
      s1_reg <= {power_down_n_pin_i, i2c_mode_strap_i, serial_select_n_i, serial_clock_in_i,
                 serial_data_in_i, scl_i, sda_i, 1'b1};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign pd_n = s2_reg[7];
  assign strap = s2_reg[6];
  assign cs_n = s2_reg[5];
  assign sclk_rise = s2_reg[4] & ~s3_reg[4];
  assign scl = s2_reg[2];
  assign sda = s2_reg[1];
  assign scl_rise = scl & ~s3_reg[2];
  assign scl_fall = ~scl & s3_reg[2];
  assign i2c_start = scl & s3_reg[2] & ~sda & s3_reg[1];
  assign i2c_stop = scl & s3_reg[2] & sda & ~s3_reg[1];
  // ---------------------------------------------------------------
  // route register
  // ---------------------------------------------------------------
  logic [7:0] route_reg;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  // fixed bits never stored, so sloppy writes cannot leak
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_reg <= vsw_pkg::RST_INPUT_ROUTE; // see [R3] see [R4]
    end else if (!pd_n) begin
      route_reg <= vsw_pkg::RST_INPUT_ROUTE; // see [R5]
    end else if (wr_en && wr_addr == vsw_pkg::ADDR_INPUT_ROUTE) begin
      route_reg <= wr_data & vsw_pkg::ROUTE_RD_MASK; // see [R6] see [R7]
    end
  end
  // reserved address reads zero
  assign rd_data = (wr_addr == vsw_pkg::ADDR_INPUT_ROUTE) ?
                   (route_reg & vsw_pkg::ROUTE_RD_MASK) : 8'h00; // see [R12]
  assign output1_source_select_o = route_reg[vsw_pkg::SEL1_LSB +: 3]; // see [R1]
  assign output2_source_select_o = route_reg[vsw_pkg::SEL2_LSB +: 3]; // see [R2]
  // one-hot route, zero grounds the output
  function automatic logic [6:0] route_dec(input logic [2:0] sel);
    route_dec = (sel == 3'h0) ? 7'h00 : 7'((8'h01 << sel) >> 1); // see [R8]
  endfunction
  assign video_output_one_route_o = route_dec(output1_source_select_o);
  assign video_output_two_route_o = route_dec(output2_source_select_o);
  // ---------------------------------------------------------------
  // 3-wire receiver
  // ---------------------------------------------------------------
  logic [15:0] tw_sh_reg;
  logic [4:0] tw_cnt_reg;
  logic [15:0] tw_frame;
  logic tw_hit;
  assign tw_frame = {tw_sh_reg[14:0], s2_reg[3]};
  assign tw_hit = sclk_rise && !cs_n && !strap && tw_cnt_reg == 5'(vsw_pkg::TW_FRAME_BITS - 1) &&
                  tw_frame[15:14] == {chip_addr_bit_high_i, chip_addr_bit_low_i} &&
                  tw_frame[13]; // see [R10]
  // counter restarts while select is high, so a short frame is dropped
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tw_sh_reg <= 16'h0000;
      tw_cnt_reg <= 5'h00;
    end else if (cs_n || strap) begin
      tw_cnt_reg <= 5'h00;
    end else if (sclk_rise && tw_cnt_reg != 5'(vsw_pkg::TW_FRAME_BITS)) begin
      tw_sh_reg <= tw_frame;
      tw_cnt_reg <= tw_cnt_reg + 5'h01;
    end
  end
  // ---------------------------------------------------------------
  // two-wire slave
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_DATA, I_RD, I_ACK, I_RACK} vsw_i2c_e;
  vsw_i2c_e st_reg;
  vsw_i2c_e ret_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic [4:0] ptr_reg;
  logic rd_mode_reg;
  logic drive_reg;
  logic i_wr;
  logic dev_match;
  assign dev_match = sh_reg[7:3] == vsw_pkg::I2C_ADDR_FIXED &&
                     sh_reg[2:1] == {chip_addr_bit_low_i, chip_addr_bit_high_i};
  assign i_wr = scl_rise && st_reg == I_DATA && bit_reg == 4'h7 && strap;
  assign wr_en = tw_hit || i_wr; // see [R9]
  assign wr_addr = tw_hit ? tw_frame[12:8] : ptr_reg;
  assign wr_data = tw_hit ? tw_frame[7:0] : {sh_reg[6:0], sda};
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_reg;
  // byte engine: shift on scl rise, change sda on scl fall
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= I_IDLE;
      ret_reg <= I_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      ptr_reg <= 5'h00;
      rd_mode_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else if (!strap || !pd_n || i2c_stop) begin
      st_reg <= I_IDLE;
      drive_reg <= 1'b0;
    end else if (i2c_start) begin
      st_reg <= I_DEV;
      bit_reg <= 4'h0;
      drive_reg <= 1'b0;
    end else begin
      case (st_reg)
        I_DEV, I_REG, I_DATA: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda};
            bit_reg <= bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            if (st_reg == I_DEV && !dev_match) begin
              st_reg <= I_IDLE;
            end else begin
              drive_reg <= 1'b1;
              st_reg <= I_ACK;
              if (st_reg == I_DEV) begin
                rd_mode_reg <= sh_reg[0];
                ret_reg <= sh_reg[0] ? I_RD : I_REG;
              end else if (st_reg == I_REG) begin
                ptr_reg <= sh_reg[4:0];
                ret_reg <= I_DATA;
              end else begin
                ptr_reg <= ptr_reg + 5'h01; // see [R11]
                ret_reg <= I_DATA;
              end
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            st_reg <= ret_reg;
            drive_reg <= ret_reg == I_RD && !rd_data[7];
            sh_reg <= {rd_data[6:0], 1'b0};
            bit_reg <= 4'h1;
            if (ret_reg == I_RD) begin
              ptr_reg <= ptr_reg + 5'h01;
            end else begin
              bit_reg <= 4'h0;
            end
          end
        end
        I_RD: begin
          if (scl_fall) begin
            if (bit_reg == 4'h8) begin
              drive_reg <= 1'b0;
              st_reg <= I_RACK;
            end else begin
              drive_reg <= !sh_reg[7];
              sh_reg <= {sh_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            st_reg <= sda ? I_IDLE : I_ACK;
            ret_reg <= I_RD;
          end
        end
        default: st_reg <= I_IDLE;
      endcase
    end
  end
endmodule // vsw_ctrl

// File: dv/vsw_ctrl_props.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// route bank checker
// ---------------------------------------------------------------
module vsw_ctrl_props (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // pins
  input wire logic power_down_n_pin_i,
  input wire logic i2c_mode_strap_i,
  input wire logic serial_select_n_i,
  input wire logic scl_i,
  // outputs
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [2:0] output1_source_select_o,
  input wire logic [2:0] output2_source_select_o,
  input wire logic [6:0] video_output_one_route_o,
  input wire logic [6:0] video_output_two_route_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // select value n routes input n at bit n-1, zero grounds
  function automatic logic [6:0] hot(input logic [2:0] s);
    return (s == 3'h0) ? 7'h00 : 7'h01 << (s - 3'h1);
  endfunction
  // route outputs, reset, power-down and idle stability
  route_one_a: assert property (video_output_one_route_o == hot(output1_source_select_o))
    else $error("route one wrong");
  route_two_a: assert property (video_output_two_route_o == hot(output2_source_select_o))
    else $error("route two wrong");
  reset_clear_a: assert property ($rose(rst_b_i) |-> {output2_source_select_o,
    output1_source_select_o} == 6'h00) else $error("selects not cleared by reset");
  pd_clear_a: assert property ((!power_down_n_pin_i)[*5] |-> {output2_source_select_o,
    output1_source_select_o} == 6'h00) else $error("selects not cleared by power-down");
  cs_idle_a: assert property ((!i2c_mode_strap_i && serial_select_n_i && power_down_n_pin_i)[*8]
    |=> $stable({output2_source_select_o, output1_source_select_o})) else $error("3-wire idle change");
  scl_idle_a: assert property ((i2c_mode_strap_i && scl_i && power_down_n_pin_i)[*8]
    |=> $stable({output2_source_select_o, output1_source_select_o})) else $error("two-wire idle change");
  no_ack_drive_a: assert property ((!i2c_mode_strap_i)[*4] |-> !sda_oe_o)
    else $error("sda driven in 3-wire mode");
  sda_level_a: assert property (!sda_o) else $error("sda driven high");
  // main scenarios
  cover property ($changed(output1_source_select_o));
  cover property ($rose(sda_oe_o));
  cover property ((!power_down_n_pin_i)[*5]);
endmodule // vsw_ctrl_props
bind vsw_ctrl vsw_ctrl_props u_vsw_ctrl_props (.*);

// File: dv/vsw_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side of both serial ports
// ---------------------------------------------------------------
module vsw_host_model (
  // clock
  input wire logic ref_clk_i,
  // 3-wire pins
  output logic serial_select_n_o = 1'b1,
  output logic serial_clock_in_o = 1'b0,
  output logic serial_data_in_o = 1'b0,
  // two-wire pins, pull high means sda held low
  output logic scl_o = 1'b1,
  output logic sda_pull_o = 1'b0,
  input wire logic sda_i
);
  // four clocks a level, well above the two-flop sync
  task automatic hold();
    repeat (4) @(posedge ref_clk_i);
  endtask
  // frame msb first; fixed bits forced to zero, clock still outside frames
  task automatic tw_write(input logic [1:0] cad, input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {cad, 1'b1, a, d & 8'h77};
    serial_select_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_clock_in_o <= 1'b0;
      serial_data_in_o <= f[i];
      hold();
      serial_clock_in_o <= 1'b1;
      hold();
    end
    serial_clock_in_o <= 1'b0;
    hold();
    serial_select_n_o <= 1'b1;
    serial_data_in_o <= ~f[0]; // stale data must not read as valid
    hold();
  endtask
  // sda only moves while scl is low; line sampled mid-cycle, away from edges
  task automatic tw2_bit(input logic b, output logic seen);
    scl_o <= 1'b0;
    hold();
    sda_pull_o <= ~b;
    hold();
    scl_o <= 1'b1;
    hold();
    @(negedge ref_clk_i) seen = sda_i;
    @(posedge ref_clk_i);
  endtask
  task automatic tw2_byte(input logic [7:0] v, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) tw2_bit(v[i], s);
    tw2_bit(1'b1, ack_n);
  endtask
  // start, device byte, register zero only, one data byte, stop
  task automatic tw2_write(input logic [7:0] dev, input logic [7:0] d, output logic [2:0] ack_n);
    sda_pull_o <= 1'b1;
    hold();
    tw2_byte(dev, ack_n[2]);
    tw2_byte(8'h00, ack_n[1]);
    tw2_byte(d & 8'h77, ack_n[0]);
    scl_o <= 1'b0;
    sda_pull_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_pull_o <= 1'b0;
    hold();
  endtask
  // random read of two bytes: dummy write of the pointer, repeated start, ack, nack, stop
  task automatic tw2_read(input logic [7:0] dev, input logic [4:0] a, output logic [15:0] q,
                          output logic [2:0] ack_n);
    logic s;
    sda_pull_o <= 1'b1;
    hold();
    tw2_byte({dev[7:1], 1'b0}, ack_n[2]);
    tw2_byte({3'h0, a}, ack_n[1]);
    // repeated start: release sda with scl low, raise scl, then pull sda
    scl_o <= 1'b0;
    hold();
    sda_pull_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_pull_o <= 1'b1;
    hold();
    tw2_byte({dev[7:1], 1'b1}, ack_n[0]);
    for (int i = 15; i >= 0; i--) begin
      tw2_bit(1'b1, q[i]);
      if (i == 8) begin
        tw2_bit(1'b0, s);
      end
    end
    tw2_bit(1'b1, s);
    scl_o <= 1'b0;
    sda_pull_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_pull_o <= 1'b0;
    hold();
  endtask
endmodule // vsw_host_model

// File: dv/vsw_ctrl_tb_top.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// route bank bench
// ---------------------------------------------------------------
module vsw_ctrl_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic pd_n = 1'b1;
  logic strap = 1'b0;
  logic [1:0] cad = 2'h2;
  logic cs_n, sclk, sdat, scl, pull, sda_w, sda_o, sda_oe;
  logic [2:0] sel1, sel2, ack_n;
  logic [6:0] rt1, rt2;
  logic [15:0] rd;
  int n_fail = 0;
  int tests_run = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  // pulled-up open-drain line
  assign sda_w = ~(pull | sda_oe);
  vsw_ctrl u_vsw_ctrl (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .power_down_n_pin_i(pd_n),
    .i2c_mode_strap_i(strap), .chip_addr_bit_high_i(cad[1]), .chip_addr_bit_low_i(cad[0]),
    .serial_select_n_i(cs_n), .serial_clock_in_i(sclk), .serial_data_in_i(sdat), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .output1_source_select_o(sel1),
    .output2_source_select_o(sel2), .video_output_one_route_o(rt1),
    .video_output_two_route_o(rt2));
  vsw_host_model u_vsw_host_model (.ref_clk_i(ref_clk_i), .serial_select_n_o(cs_n),
    .serial_clock_in_o(sclk), .serial_data_in_o(sdat), .scl_o(scl), .sda_pull_o(pull),
    .sda_i(sda_w));
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // selects, then routes with input n at bit n-1
  task automatic check_out(input logic [2:0] e1, input logic [2:0] e2);
    check({8'h00, sel2, sel1}, {8'h00, e2, e1});
    check({rt2, rt1}, {(e2 == 3'h0) ? 7'h00 : 7'h01 << (e2 - 3'h1),
      (e1 == 3'h0) ? 7'h00 : 7'h01 << (e1 - 3'h1)});
  endtask
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // runs are about 3100 clocks
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check_out(3'h0, 3'h0);
    for (int v = 0; v < 8; v++) begin
      u_vsw_host_model.tw_write(cad, 5'h00, {1'b0, 3'(v), 1'b0, 3'(7 - v)});
      check_out(3'(7 - v), 3'(v));
    end
    u_vsw_host_model.tw_write(2'h1, 5'h00, 8'h11);
    check_out(3'h0, 3'h7);
    strap <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    u_vsw_host_model.tw_write(cad, 5'h00, 8'h11);
    check_out(3'h0, 3'h7);
    u_vsw_host_model.tw2_write({vsw_pkg::I2C_ADDR_FIXED, cad[0], cad[1], 1'b0}, 8'h35, ack_n);
    check({11'h000, ack_n}, 14'h0000);
    check_out(3'h5, 3'h3);
    // read back address zero then the reserved address
    u_vsw_host_model.tw2_read({vsw_pkg::I2C_ADDR_FIXED, cad[0], cad[1], 1'b0}, 5'h00, rd, ack_n);
    check({11'h000, ack_n}, 14'h0000);
    check({6'h00, rd[15:8]}, 14'h0035);
    check({6'h00, rd[7:0]}, 14'h0000);
    u_vsw_host_model.tw2_write({vsw_pkg::I2C_ADDR_FIXED, ~cad[0], cad[1], 1'b0}, 8'h11, ack_n);
    check({13'h0000, ack_n[2]}, 14'h0001);
    check_out(3'h5, 3'h3);
    pd_n <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    check_out(3'h0, 3'h0);
    // second reset in mid-run, from a non-zero route
    pd_n <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    u_vsw_host_model.tw2_write({vsw_pkg::I2C_ADDR_FIXED, cad[0], cad[1], 1'b0}, 8'h62, ack_n);
    check_out(3'h2, 3'h6);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check_out(3'h0, 3'h0);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check_out(3'h0, 3'h0);
    stop_test();
  end
endmodule // vsw_ctrl_tb_top
